// ==== logic/aad_adder.sv ====
// Eight-bit adder that yields sum and the four arithmetic flags.
`timescale 1ns/1ps
`include "aad_defines.svh"
module aad_adder
(
    // Operands
    input  wire logic [7:0]            a_i,
    input  wire logic [7:0]            b_i,
    // Result
    output aad_pkg::aad_alu_out_t      out_o
);
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    always_comb
    begin
        low_sum  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        full_sum = {1'b0, a_i} + {1'b0, b_i};
        out_o.result                = full_sum[7:0];
        out_o.flags.carry           = full_sum[8];
        out_o.flags.nibble_wrap_bit = low_sum[4];
        out_o.flags.zero            = (full_sum[7:0] == 8'h00);
        // Same-sign operands giving a different-sign result is signed overflow.
        out_o.flags.signed_wrap_bit = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
    end
endmodule

// ==== logic/aad_core.sv ====
// Accumulator datapath: add into memory, three AND forms and an immediate load.
`timescale 1ns/1ps
`include "aad_defines.svh"
module aad_core
#(
    parameter int ADDR_W = `AAD_ADDR_W
)
(
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    // Instruction issue
    input  wire logic                     op_valid_i,
    input  wire aad_pkg::aad_op_t         op_i,
    input  wire logic [7:0]               imm_i,
    input  wire logic [ADDR_W-1:0]        mem_addr_i,
    input  wire logic [7:0]               mem_rdata_i,
    // Data memory write port
    output logic                          mem_we_o,
    output logic      [ADDR_W-1:0]        mem_addr_o,
    output logic      [7:0]               mem_wdata_o,
    // Architectural state
    output logic      [7:0]               working_register_o,
    output aad_pkg::aad_flags_t           flags_o
);
    aad_pkg::aad_alu_out_t add_out;
    logic [7:0]            and_b;
    logic [7:0]            and_res;
    logic                  and_zero;
    logic                  go;

    // Op groups are decoded in several places, so they live in one spot.
    function automatic logic writes_wreg(input aad_pkg::aad_op_t op);
        return (op == aad_pkg::AAD_OP_AND_WREG) || (op == aad_pkg::AAD_OP_AND_IMM);
    endfunction

    function automatic logic writes_mem(input aad_pkg::aad_op_t op);
        return (op == aad_pkg::AAD_OP_SUM_MEM) || (op == aad_pkg::AAD_OP_MASK_MEM);
    endfunction

    // Reference flag equations for the checks, kept apart from the adder on purpose.
    function automatic logic ref_carry(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8];
    endfunction

    function automatic logic ref_nibble(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return s[4];
    endfunction

    // A nine-bit signed sum whose top two bits disagree has wrapped.
    function automatic logic ref_signed(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {a[7], a} + {b[7], b};
        return s[8] ^ s[7];
    endfunction

    assign go    = op_valid_i;
    // Immediate form takes the instruction byte, others the memory byte.
    assign and_b = (op_i == aad_pkg::AAD_OP_AND_IMM) ? imm_i : mem_rdata_i;

    aad_adder u_add
    (
        .a_i   (working_register_o),
        .b_i   (mem_rdata_i),
        .out_o (add_out)
    );

    aad_logic u_and
    (
        .a_i      (working_register_o),
        .b_i      (and_b),
        .result_o (and_res),
        .zero_o   (and_zero)
    );

    // Working register updates.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            working_register_o <= `AAD_WREG_RESET;
        else if (go && writes_wreg(op_i))
            working_register_o <= and_res;
        else if (go && op_i == aad_pkg::AAD_OP_LOAD_IMM)
            working_register_o <= imm_i;
    end

    // Status flags; AND forms touch only zero.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            flags_o <= `AAD_FLAG_RESET;
        else if (go && op_i == aad_pkg::AAD_OP_SUM_MEM)
            flags_o <= add_out.flags;
        else if (go && writes_wreg(op_i))
            flags_o.zero <= and_zero;
        else if (go && op_i == aad_pkg::AAD_OP_MASK_MEM)
            flags_o.zero <= and_zero;
    end

    // Memory write-back, one cycle after issue.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mem_we_o    <= 1'b0;
            mem_addr_o  <= {ADDR_W{1'b0}};
            mem_wdata_o <= 8'h00;
        end
        else
        begin
            mem_we_o   <= go && writes_mem(op_i);
            mem_addr_o <= mem_addr_i;
            if (go && op_i == aad_pkg::AAD_OP_SUM_MEM)
                mem_wdata_o <= add_out.result;
            else if (go && op_i == aad_pkg::AAD_OP_MASK_MEM)
                mem_wdata_o <= and_res;
        end
    end

    property p_sum_write;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=>
            mem_we_o && mem_wdata_o == $past(working_register_o + mem_rdata_i);
    endproperty
    a_sum_write: assert property (p_sum_write) else $error("sum not written");

    property p_and_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_WREG) |=>
            working_register_o == ($past(working_register_o) & $past(mem_rdata_i))
            && $stable(flags_o.carry) && !mem_we_o;
    endproperty
    a_and_mem: assert property (p_and_mem) else $error("and memory wrong");

    property p_and_imm;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_IMM) |=>
            working_register_o == ($past(working_register_o) & $past(imm_i))
            && $stable(flags_o.signed_wrap_bit);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

    property p_mask_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_MASK_MEM) |=>
            mem_we_o && mem_wdata_o == ($past(working_register_o) & $past(mem_rdata_i))
            && $stable(working_register_o);
    endproperty
    a_mask_mem: assert property (p_mask_mem) else $error("mask write wrong");

    property p_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=>
            flags_o.zero == (mem_wdata_o == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    // Reset clears working register, flags, write enable and write data, whatever was requested beside it.
    property p_reset_clear;
        @(posedge clk_sys_i)
        rst_i |=> working_register_o == `AAD_WREG_RESET && flags_o == `AAD_FLAG_RESET
            && !mem_we_o && mem_wdata_o == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

    property p_idle;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!op_valid_i || op_i == aad_pkg::AAD_OP_NONE) |=>
            !mem_we_o && $stable(working_register_o) && $stable(flags_o)
            && $stable(mem_wdata_o);
    endproperty
    a_idle: assert property (p_idle) else $error("state changed without an op");

    property p_we_cause;
        @(posedge clk_sys_i) disable iff (rst_i)
        mem_we_o |-> $past(op_valid_i) && writes_mem($past(op_i));
    endproperty
    a_we_cause: assert property (p_we_cause) else $error("stray memory write");

    // Flag checks for the add, against the reference equations above.
    property p_sum_carry;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=>
            flags_o.carry == $past(ref_carry(working_register_o, mem_rdata_i));
    endproperty
    a_sum_carry: assert property (p_sum_carry) else $error("carry flag wrong");

    property p_sum_nibble;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=>
            flags_o.nibble_wrap_bit == $past(ref_nibble(working_register_o, mem_rdata_i));
    endproperty
    a_sum_nibble: assert property (p_sum_nibble) else $error("nibble flag wrong");

    property p_sum_signed;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=>
            flags_o.signed_wrap_bit == $past(ref_signed(working_register_o, mem_rdata_i));
    endproperty
    a_sum_signed: assert property (p_sum_signed) else $error("signed flag wrong");

    property p_sum_keeps_wreg;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=> $stable(working_register_o);
    endproperty
    a_sum_keeps_wreg: assert property (p_sum_keeps_wreg) else $error("sum moved wreg");

    property p_sum_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_SUM_MEM) |=> mem_addr_o == $past(mem_addr_i);
    endproperty
    a_sum_addr: assert property (p_sum_addr) else $error("sum address wrong");

    property p_mask_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_MASK_MEM) |=> mem_addr_o == $past(mem_addr_i);
    endproperty
    a_mask_addr: assert property (p_mask_addr) else $error("mask address wrong");

    // The AND forms may touch zero and nothing else among the flags.
    property p_and_mem_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_WREG) |=>
            flags_o.zero == (working_register_o == 8'h00)
            && $stable(flags_o.nibble_wrap_bit) && $stable(flags_o.signed_wrap_bit);
    endproperty
    a_and_mem_zero: assert property (p_and_mem_zero) else $error("and memory flags wrong");

    property p_and_mem_keeps_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_WREG) |=> $stable(mem_wdata_o);
    endproperty
    a_and_mem_keeps_mem: assert property (p_and_mem_keeps_mem) else $error("and wrote data");

    property p_and_imm_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_IMM) |=>
            flags_o.zero == (working_register_o == 8'h00) && !mem_we_o
            && $stable(flags_o.carry) && $stable(flags_o.nibble_wrap_bit);
    endproperty
    a_and_imm_zero: assert property (p_and_imm_zero) else $error("and immediate flags wrong");

    property p_and_imm_keeps_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_AND_IMM) |=> $stable(mem_wdata_o);
    endproperty
    a_and_imm_keeps_mem: assert property (p_and_imm_keeps_mem) else $error("imm wrote data");

    property p_mask_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_MASK_MEM) |=>
            flags_o.zero == (mem_wdata_o == 8'h00) && $stable(flags_o.carry)
            && $stable(flags_o.nibble_wrap_bit) && $stable(flags_o.signed_wrap_bit);
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("mask flags wrong");

    // The load is a plain move: no flag and no memory write.
    property p_load;
        @(posedge clk_sys_i) disable iff (rst_i)
        (op_valid_i && op_i == aad_pkg::AAD_OP_LOAD_IMM) |=>
            working_register_o == $past(imm_i) && $stable(flags_o) && !mem_we_o;
    endproperty
    a_load: assert property (p_load) else $error("load wrong");
endmodule

// ==== logic/aad_defines.svh ====
// Constants for the accumulator add and logic datapath.
// Functional notes
// - Sum-into-memory adds working register to memory byte, writes memory, sets four flags.
// - AND with memory leaves result in working register, updates zero flag only.
// - AND immediate leaves result in working register, updates zero flag only.
// - Mask-into-memory ANDs memory byte with working register, writes result to memory.
`ifndef AAD_DEFINES_SVH
`define AAD_DEFINES_SVH
`define AAD_DATA_W      8
`define AAD_ADDR_W      8
`define AAD_WREG_RESET  8'h00
`define AAD_FLAG_RESET  4'h0
`define AAD_FLAG_CARRY  0
`define AAD_FLAG_NIBBLE 1
`define AAD_FLAG_ZERO   2
`define AAD_FLAG_SIGNED 3
`endif

// ==== logic/aad_logic.sv ====
// Bitwise AND unit with zero detection.
`timescale 1ns/1ps
module aad_logic
(
    // Operands
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    // Result
    output logic      [7:0] result_o,
    output logic            zero_o
);
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_bit
            assign result_o[g] = a_i[g] & b_i[g];
        end
    endgenerate

    assign zero_o = (result_o == 8'h00);
endmodule

// ==== logic/aad_pkg.sv ====
// Types for the accumulator add and logic datapath.
package aad_pkg;
    typedef enum logic [2:0]
    {
        AAD_OP_NONE     = 3'b000,
        AAD_OP_SUM_MEM  = 3'b001,
        AAD_OP_AND_WREG = 3'b010,
        AAD_OP_AND_IMM  = 3'b011,
        AAD_OP_MASK_MEM = 3'b100,
        // Loads the immediate into the working register. Without it the register never leaves zero.
        AAD_OP_LOAD_IMM = 3'b101
    } aad_op_t;

    typedef struct packed
    {
        logic signed_wrap_bit;
        logic zero;
        logic nibble_wrap_bit;
        logic carry;
    } aad_flags_t;

    typedef struct packed
    {
        logic [7:0] result;
        aad_flags_t flags;
    } aad_alu_out_t;
endpackage

// ==== test/aad_core_tb_top.sv ====
// Self-checking random testbench for the accumulator datapath core.
`timescale 1ns/1ps
module aad_core_tb_top;
    logic                clk_sys_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                op_valid_i = 1'b0;
    aad_pkg::aad_op_t    op_i = aad_pkg::AAD_OP_NONE;
    logic [7:0]          imm_i = 8'h00;
    logic [7:0]          mem_addr_i = 8'h00;
    logic [7:0]          mem_rdata_i = 8'h00;
    logic                mem_we_o;
    logic [7:0]          mem_addr_o;
    logic [7:0]          mem_wdata_o;
    logic [7:0]          working_register_o;
    aad_pkg::aad_flags_t flags_o;
    aad_pkg::aad_flags_t ef = '0;
    logic [7:0]          ew = 8'h00;
    logic [7:0]          ea = 8'h00;
    logic [7:0]          ed = 8'h00;
    logic                ewe = 1'b0;
    logic [31:0]         seed = 32'ha8fea37d;
    int                  n_fail = 0;
    int                  n_compared = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    aad_core dut
    (
        .clk_sys_i          (clk_sys_i),
        .rst_i              (rst_i),
        .op_valid_i         (op_valid_i),
        .op_i               (op_i),
        .imm_i              (imm_i),
        .mem_addr_i         (mem_addr_i),
        .mem_rdata_i        (mem_rdata_i),
        .mem_we_o           (mem_we_o),
        .mem_addr_o         (mem_addr_o),
        .mem_wdata_o        (mem_wdata_o),
        .working_register_o (working_register_o),
        .flags_o            (flags_o)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Flags of an eight-bit add, in the package's field order.
    function automatic aad_pkg::aad_flags_t add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
                ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
    endfunction

    // Opening cases: load-and-add pairs that force carry, nibble and signed wrap, then each AND form.
    function automatic aad_pkg::aad_op_t corner_op(input int k);
        case (k)
            0, 2, 4, 8: return aad_pkg::AAD_OP_LOAD_IMM;
            1, 3, 5:    return aad_pkg::AAD_OP_SUM_MEM;
            6:          return aad_pkg::AAD_OP_AND_WREG;
            7:          return aad_pkg::AAD_OP_AND_IMM;
            default:    return aad_pkg::AAD_OP_MASK_MEM;
        endcase
    endfunction

    function automatic logic [7:0] corner_val(input int k);
        case (k)
            0:       return 8'hff;
            1, 5:    return 8'h01;
            2, 3:    return 8'h80;
            4:       return 8'h7f;
            6:       return 8'h0f;
            7:       return 8'hf0;
            8:       return 8'h3c;
            default: return 8'hff;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Advances the expected state by the request driven at this edge, which the DUT takes at the next edge.
    task automatic model;
        ewe = 1'b0;
        if (rst_i)
        begin
            ew = 8'h00;
            ed = 8'h00;
            ef = '0;
        end
        else if (op_valid_i)
        begin
            case (op_i)
                aad_pkg::AAD_OP_SUM_MEM:
                begin
                    ewe = 1'b1;
                    ea  = mem_addr_i;
                    ed  = ew + mem_rdata_i;
                    ef  = add_flags(ew, mem_rdata_i);
                end
                aad_pkg::AAD_OP_AND_WREG:
                begin
                    ew      = ew & mem_rdata_i;
                    ef.zero = ew == 8'h00;
                end
                aad_pkg::AAD_OP_AND_IMM:
                begin
                    ew      = ew & imm_i;
                    ef.zero = ew == 8'h00;
                end
                aad_pkg::AAD_OP_MASK_MEM:
                begin
                    ewe     = 1'b1;
                    ea      = mem_addr_i;
                    ed      = ew & mem_rdata_i;
                    ef.zero = ed == 8'h00;
                end
                aad_pkg::AAD_OP_LOAD_IMM:
                begin
                    ew = imm_i;
                end
                default:
                begin
                end
            endcase
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk_sys_i);
            seed = xs(seed);
            // A second reset in mid-run, three cycles long, with random ops beside it.
            rst_i       <= (i >= 200) && (i < 203);
            op_valid_i  <= (i < 10) || (seed[31:30] != 2'b00);
            op_i        <= (i < 10) ? corner_op(i) : aad_pkg::aad_op_t'(3'(seed[10:0] % 6));
            imm_i       <= (i < 10) ? corner_val(i) : seed[7:0];
            mem_addr_i  <= seed[15:8];
            mem_rdata_i <= (i < 10) ? corner_val(i) : seed[23:16];
            #1;
            chk("mem_we", {7'h00, ewe}, {7'h00, mem_we_o});
            chk("mem_wdata", ed, mem_wdata_o);
            if (ewe)
            begin
                chk("mem_addr", ea, mem_addr_o);
            end
            chk("working_register", ew, working_register_o);
            chk("flags", {4'h0, ef}, {4'h0, flags_o});
            model();
        end
        stop_test();
    end
endmodule
